// ===== qtc_adc_model.sv
// Purpose: Temperature converter model on the far side of the core.
// Assumes: One clock; the bench sets the latency of each conversion.
// Notes:   Code lines toggle outside the valid pulse.
`timescale 1ns/1ps
module qtc_adc_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Request from the bench
   input wire logic conv_start,
   input wire logic [9:0] conv_value,
   input wire logic [3:0] conv_lat,
   // Converter output
   output logic [9:0] temp_code,
   output logic temp_valid
);
   logic [3:0] cnt;
   logic [9:0] held;
   // Latency countdown; junk on the code lines so a late sample fails
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt <= 4'h0;
         held <= 10'h000;
         temp_valid <= 1'b0;
         temp_code <= 10'h155;
      end
      else
      begin
         temp_valid <= (cnt == 4'h1);
         temp_code <= (cnt == 4'h1) ? held : ~temp_code;
         if (conv_start)
         begin
            cnt <= conv_lat;
            held <= conv_value;
         end
         else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
      end
   end
endmodule : qtc_adc_model

// ===== qtc_core.sv
// Purpose: Quadratic temperature compensation of fine gain and fine offset,
//          calibration memory with voting, clamp and fault band selection.
// Assumes: Temperature and filter codes come from converters on clk_sys;
//          fault detector levels are asynchronous and are synchronised.
// Notes:   Registers reached over Avalon-MM with one wait state.
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "qtc_regs.svh"
module qtc_core
   import qtc_pkg::*;
#(
   parameter int TEMP_W = 10,
   parameter int CODE_W = 10
)(
   // Clock, reset and freeze
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   // Avalon-MM register slave
   input wire logic [`QTC_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Temperature converter
   input wire logic [TEMP_W-1:0] temp_code,
   input wire logic temp_valid,
   // Filter node converter
   input wire logic [CODE_W-1:0] filtered_signal_node,
   // Asynchronous fault detectors
   input wire logic flt_short_vdd,
   input wire logic input_fault,
   input wire logic supply_open,
   // Converter codes
   output logic [9:0] fine_gain_fraction,
   output logic [9:0] fine_offset_fraction,
   output logic [6:0] coarse_offset_code,
   output logic [2:0] low_clamp_code,
   output logic [2:0] high_clamp_code,
   output logic input_swap_bit,
   // Output stage
   output logic [CODE_W-1:0] clamped_output,
   output logic [1:0] fault_band,
   output logic range_fault
);

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [63:0][2:0][4:0] mem;
      logic wait_q;
      logic [31:0] rdata;
      logic auto_eval;
      logic [2:0] copy_mask;
      logic done;
      qtc_state_type state;
      logic [TEMP_W-1:0] temp;
      logic signed [11:0] dt;
      logic signed [23:0] sq;
      logic signed [23:0] g1dt;
      logic signed [23:0] o1dt;
      logic [9:0] gain;
      logic [9:0] offs;
      logic gain_bad;
      logic offs_bad;
      logic rfault;
      logic par_err;
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [6:0] coarse;
      logic [2:0] clo;
      logic [2:0] chi;
      logic swap;
      logic [CODE_W-1:0] outv;
      qtc_band_type band;
   } qtc_st_type;

   qtc_st_type s;
   qtc_st_type next_s;

   // -------------------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------------------
   // Bitwise two-of-three vote
   function automatic logic [4:0] qtc_vote(input logic [4:0] a, input logic [4:0] b,
                                           input logic [4:0] c);
      qtc_vote = (a & b) | (a & c) | (b & c);
   endfunction : qtc_vote

   // True when the count of ones is odd
   function automatic logic qtc_odd(input logic [4:0] v);
      qtc_odd = ^v;
   endfunction : qtc_odd

   // -------------------------------------------------------------------------
   // Voting of every location
   // -------------------------------------------------------------------------
   logic [63:0][4:0] voted;
   genvar gi;
   generate
      for (gi = 0; gi < 64; gi++)
      begin : g_vote
         // Vote on every access; a single bad copy never reaches the ALU
         assign voted[gi] = qtc_vote(s.mem[gi][0], s.mem[gi][1], s.mem[gi][2]);
      end
   endgenerate

   // Three consecutive nibbles, lowest location holds the low nibble
   function automatic logic [11:0] qtc_word(input logic [63:0][4:0] v,
                                            input logic [5:0] loc);
      logic [5:0] l1;
      logic [5:0] l2;
      l1 = loc + 6'h01;
      l2 = loc + 6'h02;
      qtc_word = {v[l2][3:0], v[l1][3:0], v[loc][3:0]};
   endfunction : qtc_word

   // -------------------------------------------------------------------------
   // Coefficient fields
   // -------------------------------------------------------------------------
   logic [11:0] t1_w;
   logic [11:0] g0_w;
   logic [11:0] g1_w;
   logic [11:0] g2_w;
   logic [11:0] o0_w;
   logic [11:0] o1_w;
   logic [11:0] o2_w;
   assign t1_w = qtc_word(voted, `QTC_LOC_T1);
   assign g0_w = qtc_word(voted, `QTC_LOC_G0);
   assign g1_w = qtc_word(voted, `QTC_LOC_G1);
   assign g2_w = qtc_word(voted, `QTC_LOC_G2);
   assign o0_w = qtc_word(voted, `QTC_LOC_O0);
   assign o1_w = qtc_word(voted, `QTC_LOC_O1);
   assign o2_w = qtc_word(voted, `QTC_LOC_O2);

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb
   begin
      logic req;
      logic acc;
      logic in_mem;
      logic [5:0] loc;
      logic trig;
      logic signed [12:0] diff;
      logic signed [35:0] g2sq;
      logic signed [35:0] o2sq;
      logic signed [27:0] gsum;
      logic signed [27:0] osum;
      logic perr;
      logic [CODE_W-1:0] lo_thr;
      logic [CODE_W-1:0] hi_thr;
      logic hi_fault;
      logic lo_fault;
      req = read | write;
      acc = 1'b0;
      in_mem = address[`QTC_MEM_SEL_BIT];
      loc = address[7:2];
      trig = 1'b0;
      diff = '0;
      g2sq = '0;
      o2sq = '0;
      gsum = '0;
      osum = '0;
      perr = 1'b0;
      lo_thr = '0;
      hi_thr = '0;
      hi_fault = 1'b0;
      lo_fault = 1'b0;
      next_s = s;

      // Bus handshake: one wait cycle, the access acts while wait is low
      next_s.wait_q = !(req && s.wait_q);
      acc = req && !s.wait_q;

      // Read data latched one cycle early so it stands with wait low
      if (req && s.wait_q)
      begin
         next_s.rdata = 32'h0000_0000;
         if (read && in_mem)
         begin
            next_s.rdata = {27'h000_0000, voted[loc]};
         end
         else if (read)
         begin
            unique case (address)
               `QTC_OFS_CTRL:
                  next_s.rdata = {27'h000_0000, s.copy_mask, s.auto_eval, 1'b0};
               `QTC_OFS_STATUS:
                  next_s.rdata = {25'h000_0000, s.done, s.band, s.par_err,
                                  s.offs_bad, s.gain_bad, s.state != QTC_IDLE};
               `QTC_OFS_TEMP:
                  next_s.rdata = 32'(s.temp);
               `QTC_OFS_RESULT:
                  next_s.rdata = {6'h00, s.offs, 6'h00, s.gain};
               `QTC_OFS_CODES:
                  next_s.rdata = {15'h0000, s.swap, 1'b0, s.chi, 1'b0, s.clo,
                                  1'b0, s.coarse};
               default:
                  next_s.rdata = 32'h0000_0000;
            endcase
         end
      end

      // Writes take effect at the edge where wait is seen low
      if (acc && write && in_mem)
      begin
         // Masked copies let software plant a disagreeing copy
         for (int k = 0; k < 3; k++)
         begin
            if (s.copy_mask[k])
            begin
               next_s.mem[loc][k] = writedata[4:0];
            end
         end
      end
      else if (acc && write && address == `QTC_OFS_CTRL)
      begin
         next_s.auto_eval = writedata[`QTC_CTRL_AUTO];
         next_s.copy_mask = writedata[`QTC_CTRL_MASK_LO +: 3];
         trig = writedata[`QTC_CTRL_START];
      end
      else if (acc && write && address == `QTC_OFS_STATUS)
      begin
         if (writedata[`QTC_ST_DONE])
            next_s.done = 1'b0;
      end

      // Each new reading is captured while idle; in auto mode it starts a pass
      if (temp_valid && s.state == QTC_IDLE)
      begin
         next_s.temp = temp_code;
         trig = trig | s.auto_eval;
      end

      // Evaluation sequence
      unique case (s.state)
         QTC_IDLE:
         begin
            if (trig)
               next_s.state = QTC_DIFF;
         end
         QTC_DIFF:
         begin
            // Reading shifted up one bit to meet the 11-bit reference
            diff = $signed({2'b00, s.temp, 1'b0}) - $signed({2'b00, t1_w[10:0]});
            next_s.dt = diff[11:0];
            next_s.state = QTC_MUL;
         end
         QTC_MUL:
         begin
            next_s.sq = s.dt * s.dt;
            next_s.g1dt = $signed(g1_w) * s.dt;
            next_s.o1dt = $signed(o1_w) * s.dt;
            next_s.state = QTC_SUM;
         end
         QTC_SUM:
         begin
            // Slopes keep 10 fraction bits to span +/-2; all terms meet at 22
            g2sq = $signed(g2_w) * s.sq;
            o2sq = $signed(o2_w) * s.sq;
            gsum = $signed({6'h00, g0_w[9:0], 12'h000})
                   + {{3{s.g1dt[23]}}, s.g1dt, 1'b0}
                   + {{2{g2sq[35]}}, g2sq[35:10]};
            osum = $signed({6'h00, o0_w[9:0], 12'h000})
                   + {{3{s.o1dt[23]}}, s.o1dt, 1'b0}
                   + {{2{o2sq[35]}}, o2sq[35:10]};
            next_s.gain = gsum[21:12];
            next_s.offs = osum[21:12];
            // Guard bits above the fraction expose any overflow or sign
            next_s.gain_bad = gsum[27:22] != 6'h00;
            next_s.offs_bad = osum[27:22] != 6'h00;
            next_s.rfault = (gsum[27:22] != 6'h00) || (osum[27:22] != 6'h00);
            next_s.done = 1'b1;
            next_s.state = QTC_IDLE;
         end
      endcase

      // Parity of the 32 lowest calibration locations, checked continuously
      for (int p = 0; p < `QTC_PAR_LOCS; p++)
      begin
         if (!qtc_odd(voted[p]))
            perr = 1'b1;
      end
      next_s.par_err = perr;

      // Converter codes follow the voted memory
      next_s.coarse = {voted[`QTC_LOC_CS_HI][2:0], voted[`QTC_LOC_CS_LO][3:0]};
      next_s.clo = voted[`QTC_LOC_CLAMP_A][2:0];
      next_s.chi = {voted[`QTC_LOC_CLAMP_B][1:0], voted[`QTC_LOC_CLAMP_A][3]};
      next_s.swap = voted[`QTC_LOC_SWAP][0];

      // Detector levels pass two flops before any use
      next_s.sync1 = {supply_open, flt_short_vdd, input_fault};
      next_s.sync2 = s.sync1;

      // Band selection: high band wins since an open supply masks the rest
      hi_fault = s.sync2[1] | s.sync2[2];
      lo_fault = s.sync2[0] | s.gain_bad | s.offs_bad | s.par_err;
      if (hi_fault)
      begin
         next_s.band = QTC_BAND_HIGH;
      end
      else if (lo_fault)
      begin
         next_s.band = QTC_BAND_LOW;
      end
      else
      begin
         next_s.band = QTC_BAND_NORMAL;
      end

      // Clamp thresholds from the codes; fault bands sit beyond them
      lo_thr = `QTC_LOW_BASE + CODE_W'(s.clo) * `QTC_CLAMP_STEP;
      hi_thr = `QTC_HIGH_BASE - CODE_W'(3'h7 - s.chi) * `QTC_CLAMP_STEP;
      if (s.band == QTC_BAND_HIGH)
      begin
         next_s.outv = `QTC_FAULT_HIGH_CODE;
      end
      else if (s.band == QTC_BAND_LOW)
      begin
         next_s.outv = `QTC_FAULT_LOW_CODE;
      end
      else if (filtered_signal_node > hi_thr)
      begin
         next_s.outv = hi_thr;
      end
      else if (filtered_signal_node < lo_thr)
      begin
         next_s.outv = lo_thr;
      end
      else
      begin
         next_s.outv = filtered_signal_node;
      end
   end

   // -------------------------------------------------------------------------
   // Registers; clk_en low freezes everything, bus included
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
         s.wait_q <= 1'b1;
         s.copy_mask <= `QTC_RST_MASK;
         s.state <= QTC_IDLE;
         s.band <= QTC_BAND_NORMAL;
      end
      else if (clk_en)
      begin
         s <= next_s;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs, all straight from flops
   // -------------------------------------------------------------------------
   assign readdata = s.rdata;
   assign waitrequest = s.wait_q;
   assign fine_gain_fraction = s.gain;
   assign fine_offset_fraction = s.offs;
   assign coarse_offset_code = s.coarse;
   assign low_clamp_code = s.clo;
   assign high_clamp_code = s.chi;
   assign input_swap_bit = s.swap;
   assign clamped_output = s.outv;
   assign fault_band = s.band;
   assign range_fault = s.rfault;

endmodule : qtc_core

// ===== qtc_core_properties.sv
// Purpose: Port-level properties of the compensation core.
// Assumes: One clock domain; clk_en held high by the bench.
// Notes:   Fault levels pass two sync flops and the band register.
`timescale 1ns/1ps
`include "qtc_regs.svh"
module qtc_core_properties
   import qtc_pkg::*;
#(
   parameter int CODE_W = 10
)(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   // Register bus
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   // Output stage causes
   input wire logic [CODE_W-1:0] filtered_signal_node,
   input wire logic flt_short_vdd,
   input wire logic input_fault,
   input wire logic supply_open,
   input wire logic [2:0] low_clamp_code,
   input wire logic [2:0] high_clamp_code,
   // Output stage
   input wire logic [CODE_W-1:0] clamped_output,
   input wire logic [1:0] fault_band,
   input wire logic range_fault
);
   // --------
   // Helpers
   // --------
   // Clamp between the converted thresholds of the two codes
   function automatic logic [CODE_W-1:0] clamp_f(input logic [CODE_W-1:0] v,
      input logic [2:0] lc, input logic [2:0] hc);
      logic [9:0] lo;
      logic [9:0] hi;
      lo = `QTC_LOW_BASE + lc * `QTC_CLAMP_STEP;
      hi = `QTC_HIGH_BASE - (3'h7 - hc) * `QTC_CLAMP_STEP;
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp_f
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // --------
   // Properties
   // --------
   property p_wait_answer;
      (read || write) && waitrequest && clk_en |=> !waitrequest;
   endproperty
   a_wait_answer: assert property (p_wait_answer)
      else $error("bus request left without an answer");
   property p_wait_single;
      !waitrequest |=> waitrequest;
   endproperty
   a_wait_single: assert property (p_wait_single)
      else $error("answer held longer than one cycle");
   property p_short_high;
      flt_short_vdd [*5] |-> fault_band == QTC_BAND_HIGH;
   endproperty
   a_short_high: assert property (p_short_high)
      else $error("filter short did not give the high band");
   property p_open_high;
      supply_open [*5] |-> fault_band == QTC_BAND_HIGH;
   endproperty
   a_open_high: assert property (p_open_high)
      else $error("supply open did not give the high band");
   property p_input_low;
      (input_fault && !flt_short_vdd && !supply_open) [*5] |-> fault_band == QTC_BAND_LOW;
   endproperty
   a_input_low: assert property (p_input_low)
      else $error("input fault did not give the low band");
   property p_range_low;
      (range_fault && !flt_short_vdd && !supply_open) [*5] |-> fault_band == QTC_BAND_LOW;
   endproperty
   a_range_low: assert property (p_range_low)
      else $error("range fault did not give the low band");
   property p_clamp_pass;
      (fault_band == QTC_BAND_NORMAL && $stable(filtered_signal_node)
         && $stable(low_clamp_code) && $stable(high_clamp_code)) [*3]
         |-> clamped_output == clamp_f(filtered_signal_node, low_clamp_code, high_clamp_code);
   endproperty
   a_clamp_pass: assert property (p_clamp_pass)
      else $error("filter value not clamped to thresholds");
   property p_high_code;
      (fault_band == QTC_BAND_HIGH) [*2] |-> clamped_output == `QTC_FAULT_HIGH_CODE;
   endproperty
   a_high_code: assert property (p_high_code)
      else $error("high band without the high fault code");
   property p_low_code;
      (fault_band == QTC_BAND_LOW) [*2] |-> clamped_output == `QTC_FAULT_LOW_CODE;
   endproperty
   a_low_code: assert property (p_low_code)
      else $error("low band without the low fault code");
endmodule : qtc_core_properties
bind qtc_core qtc_core_properties #(.CODE_W(CODE_W)) u_props (.clk_sys, .rst_n, .clk_en,
   .read, .write, .waitrequest, .filtered_signal_node, .flt_short_vdd, .input_fault,
   .supply_open, .low_clamp_code, .high_clamp_code, .clamped_output, .fault_band,
   .range_fault);

// ===== qtc_core_tb.sv
// Purpose: Self-checking bench of the compensation core.
// Assumes: 40 MHz clock, clk_en held high, memory loaded over the bus.
// Notes:   Cases need no knowledge of the slope scaling, only signs.
`timescale 1ns/1ps
`include "qtc_regs.svh"
module qtc_core_tb
   import qtc_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [8:0] address = 9'h000;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [31:0] readdata;
   logic waitrequest;
   logic [9:0] temp_code;
   logic temp_valid;
   logic [9:0] filtered_signal_node = 10'h000;
   logic flt_short_vdd = 1'b0;
   logic input_fault = 1'b0;
   logic supply_open = 1'b0;
   logic [9:0] fine_gain_fraction;
   logic [9:0] fine_offset_fraction;
   logic [6:0] coarse_offset_code;
   logic [2:0] low_clamp_code;
   logic [2:0] high_clamp_code;
   logic input_swap_bit;
   logic [9:0] clamped_output;
   logic [1:0] fault_band;
   logic range_fault;
   logic conv_start = 1'b0;
   logic [9:0] conv_value = 10'h000;
   logic [3:0] conv_lat = 4'h1;
   logic [31:0] rd;
   int failures = 0;
   int cmp_count = 0;
   // Coefficients per case: G0 G1 G2 O0 O1 O2
   logic [11:0] cf [5][6] = '{'{12'h2C3, 12'h7FF, 12'h800, 12'h11E, 12'h801, 12'h7FF},
      '{12'h000, 12'hE00, 12'h000, 12'h100, 12'h000, 12'h000},
      '{12'h3FF, 12'h000, 12'h7FF, 12'h3FF, 12'h400, 12'h000},
      '{12'h200, 12'h000, 12'h000, 12'h000, 12'h000, 12'hC00},
      '{12'h2C3, 12'h7FF, 12'h800, 12'h11E, 12'h801, 12'h7FF}};
   logic [9:0] tmp [5] = '{10'h155, 10'h200, 10'h200, 10'h200, 10'h155};
   logic [1:0] flg [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
   logic [5:0] loc [6] = '{6'h0C, 6'h08, 6'h04, 6'h1C, 6'h18, 6'h14};
   logic [9:0] nv [7] = '{10'h000, 10'h042, 10'h043, 10'h200, 10'h3BC, 10'h3BD, 10'h3FF};
   // Short, input, open, expected band
   logic [4:0] ft [4] = '{5'b10010, 5'b01001, 5'b00110, 5'b11010};
   // Clock at 40 MHz
   always #12.5 clk_sys = ~clk_sys;
   qtc_core uut (.clk_sys, .rst_n, .clk_en(1'b1), .address, .read, .write, .writedata,
      .readdata, .waitrequest, .temp_code, .temp_valid, .filtered_signal_node,
      .flt_short_vdd, .input_fault, .supply_open, .fine_gain_fraction,
      .fine_offset_fraction, .coarse_offset_code, .low_clamp_code, .high_clamp_code,
      .input_swap_bit, .clamped_output, .fault_band, .range_fault);
   qtc_adc_model u_adc (.clk_sys, .rst_n, .conv_start, .conv_value, .conv_lat,
      .temp_code, .temp_valid);
   // --------
   // Tasks
   // --------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0d ns: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One bus access; held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      @(posedge clk_sys);
      while (waitrequest !== 1'b0)
         @(posedge clk_sys);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask : bus
   // Odd parity over the five stored bits
   task automatic mem_wr(input logic [5:0] n, input logic [3:0] v);
      bus(1'b1, 9'h100 + {1'b0, n, 2'b00}, {27'h0, ~^v, v});
   endtask : mem_wr
   task automatic load12(input logic [5:0] n, input logic [11:0] v);
      for (int i = 0; i < 3; i++)
         mem_wr(n + 6'(i), v[4*i +: 4]);
   endtask : load12
   task automatic eval(input int k);
      int n;
      for (int j = 0; j < 6; j++)
         load12(loc[j], cf[k][j]);
      // Last case runs in auto mode, where the reading itself starts the pass
      bus(1'b1, `QTC_OFS_STATUS, 32'h0000_0040);
      bus(1'b1, `QTC_OFS_CTRL, (k == 4) ? 32'h0000_001E : 32'h0000_001C);
      conv_value <= tmp[k];
      conv_lat <= 4'(k + 1);
      conv_start <= 1'b1;
      @(posedge clk_sys);
      conv_start <= 1'b0;
      n = 0;
      while (temp_valid !== 1'b1 && n < 20)
      begin
         @(posedge clk_sys);
         n++;
      end
      bus(1'b0, `QTC_OFS_TEMP, 32'h0);
      check(rd, {22'h0, tmp[k]});
      if (k != 4)
         bus(1'b1, `QTC_OFS_CTRL, 32'h0000_001D);
      rd = 32'h0;
      while (rd[`QTC_ST_DONE] !== 1'b1)
         bus(1'b0, `QTC_OFS_STATUS, 32'h0);
      check({30'h0, rd[2:1]}, {30'h0, flg[k]});
      repeat (2) @(posedge clk_sys);
      check({31'h0, range_fault}, {31'h0, |flg[k]});
      check({30'h0, fault_band}, {30'h0, (flg[k] != 2'h0) ? 2'h1 : 2'h0});
      if (flg[k] == 2'h0)
      begin
         bus(1'b0, `QTC_OFS_RESULT, 32'h0);
         check(rd, {6'h0, cf[k][3][9:0], 6'h0, cf[k][0][9:0]});
         check({fine_offset_fraction, fine_gain_fraction}, {cf[k][3][9:0], cf[k][0][9:0]});
      end
   endtask : eval
   task automatic conclude;
      if (failures == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude
   // --------
   // Sequence
   // --------
   initial
   begin
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk_sys);
      check({30'h0, fault_band}, {30'h0, QTC_BAND_LOW});
      bus(1'b0, `QTC_OFS_CTRL, 32'h0);
      check(rd, 32'h0000_001C);
      for (int i = 0; i < 32; i++)
         mem_wr(6'(i), 4'h0);
      mem_wr(6'h07, 4'h1);
      mem_wr(6'h0B, 4'h5);
      mem_wr(6'h0F, 4'h6);
      mem_wr(6'h13, 4'hA);
      mem_wr(6'h17, 4'h2);
      load12(6'h00, 12'h2AA);
      bus(1'b0, `QTC_OFS_STATUS, 32'h0);
      check({31'h0, rd[3]}, 32'h0);
      bus(1'b0, `QTC_OFS_CODES, 32'h0);
      check(rd, 32'h0001_5265);
      check({15'h0, input_swap_bit, 1'b0, high_clamp_code, 1'b0, low_clamp_code, 1'b0,
         coarse_offset_code}, 32'h0001_5265);
      bus(1'b0, 9'h014, 32'h0);
      check(rd, 32'h0);
      for (int k = 0; k < 5; k++)
         eval(k);
      // Low code 2, high code 5
      foreach (nv[i])
      begin
         filtered_signal_node <= nv[i];
         repeat (3) @(posedge clk_sys);
         check(clamped_output, (nv[i] < 10'h043) ? 10'h043 : (nv[i] > 10'h3BC) ? 10'h3BC : nv[i]);
      end
      foreach (ft[i])
      begin
         {flt_short_vdd, input_fault, supply_open} <= ft[i][4:2];
         repeat (5) @(posedge clk_sys);
         check({30'h0, fault_band}, {30'h0, ft[i][1:0]});
         check(clamped_output, ft[i][1] ? `QTC_FAULT_HIGH_CODE : `QTC_FAULT_LOW_CODE);
         {flt_short_vdd, input_fault, supply_open} <= 3'h0;
         repeat (5) @(posedge clk_sys);
      end
      // One new copy is outvoted, two win
      bus(1'b1, `QTC_OFS_CTRL, 32'h0000_0004);
      mem_wr(6'h07, 4'h0);
      bus(1'b0, 9'h11C, 32'h0);
      check(rd, 32'h0000_0001);
      bus(1'b1, `QTC_OFS_CTRL, 32'h0000_000C);
      mem_wr(6'h07, 4'h0);
      bus(1'b0, 9'h11C, 32'h0);
      check(rd, 32'h0000_0010);
      check({31'h0, input_swap_bit}, 32'h0);
      bus(1'b1, `QTC_OFS_CTRL, 32'h0000_001C);
      bus(1'b1, 9'h11C, 32'h0);
      repeat (4) @(posedge clk_sys);
      bus(1'b0, `QTC_OFS_STATUS, 32'h0);
      check({31'h0, rd[3]}, 32'h1);
      check({30'h0, fault_band}, {30'h0, QTC_BAND_LOW});
      conclude();
   end
   // Watchdog well beyond the several hundred cycles the sequence needs
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      conclude();
   end
endmodule : qtc_core_tb

// ===== qtc_pkg.sv
// Purpose: Types shared by the compensation core.
// Assumes: Nothing beyond the register header.
// Notes:   Codes are written out so waveforms read the same everywhere.
package qtc_pkg;
   // -------------------------------------------------------------------------
   // Evaluation sequence and output band
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      QTC_IDLE = 2'b00,
      QTC_DIFF = 2'b01,
      QTC_MUL = 2'b10,
      QTC_SUM = 2'b11
   } qtc_state_type;
   typedef enum logic [1:0] {
      QTC_BAND_NORMAL = 2'b00,
      QTC_BAND_LOW = 2'b01,
      QTC_BAND_HIGH = 2'b10
   } qtc_band_type;
endpackage : qtc_pkg

// ===== qtc_regs.svh
// Purpose: Offsets, field positions, locations and reset values of the
//          compensation core.
// Assumes: Byte addressing on the register bus, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef QTC_REGS_SVH
`define QTC_REGS_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define QTC_ADDR_W 9
`define QTC_OFS_CTRL 9'h000
`define QTC_OFS_STATUS 9'h004
`define QTC_OFS_TEMP 9'h008
`define QTC_OFS_RESULT 9'h00C
`define QTC_OFS_CODES 9'h010
`define QTC_MEM_SEL_BIT 8
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define QTC_CTRL_START 0
`define QTC_CTRL_AUTO 1
`define QTC_CTRL_MASK_LO 2
`define QTC_ST_DONE 6
`define QTC_RES_OFF_LO 16
`define QTC_PARITY_BIT 4
// ----------------------------------------------------------------------------
// Calibration memory locations (lowest nibble first)
// ----------------------------------------------------------------------------
`define QTC_LOC_T1 6'h00
`define QTC_LOC_G2 6'h04
`define QTC_LOC_SWAP 6'h07
`define QTC_LOC_G1 6'h08
`define QTC_LOC_CS_LO 6'h0B
`define QTC_LOC_G0 6'h0C
`define QTC_LOC_CS_HI 6'h0F
`define QTC_LOC_CLAMP_A 6'h13
`define QTC_LOC_O2 6'h14
`define QTC_LOC_CLAMP_B 6'h17
`define QTC_LOC_O1 6'h18
`define QTC_LOC_O0 6'h1C
`define QTC_PAR_LOCS 32
// ----------------------------------------------------------------------------
// Reset values and output levels
// ----------------------------------------------------------------------------
`define QTC_RST_MASK 3'h7
`define QTC_FAULT_LOW_CODE 10'h010
`define QTC_FAULT_HIGH_CODE 10'h3F0
`define QTC_LOW_BASE 10'h029
`define QTC_HIGH_BASE 10'h3D6
`define QTC_CLAMP_STEP 10'h00D
`endif
